// >>> hdl/pmr_consts.svh
// Offsets, field positions, reset values and frame counts of the PHY management bank
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH
`define PMR_REG_CTRL      5'h00
`define PMR_REG_STAT      5'h01
`define PMR_REG_ID_HI     5'h02
`define PMR_REG_ID_LO     5'h03
`define PMR_REG_ADV       5'h04
`define PMR_REG_PARTNER   5'h05
`define PMR_REG_CABLE     5'h1d
`define PMR_REG_SPECIAL   5'h1f
`define PMR_PHY1_ADDR_RST 5'h01
`define PMR_PHY2_ADDR_RST 5'h02
`define PMR_ADDR_FLD_HI   7
`define PMR_ADDR_FLD_LO   3
`define PMR_CTRL_RST      16'h1020
`define PMR_CTRL_RW_MASK  16'h7b3f
`define PMR_ADV_RST       16'h05e1
`define PMR_ADV_RW_MASK   16'h05e0
`define PMR_STAT_FIXED    16'h7800
`define PMR_CB_LOOPBACK   14
`define PMR_CB_FORCE100   13
`define PMR_CB_AN_EN      12
`define PMR_CB_PWR_DOWN   11
`define PMR_CB_AN_RESTART 9
`define PMR_CB_FULL_DPX   8
`define PMR_CB_XOVER_ALG  5
`define PMR_CB_STRAIGHT   4
`define PMR_CB_XOVER_DIS  3
`define PMR_CB_FEF_DIS    2
`define PMR_CB_TX_DIS     1
`define PMR_CB_LED_DIS    0
`define PMR_SB_AN_DONE    5
`define PMR_SB_FAR_FAULT  4
`define PMR_SB_AN_CAP     3
`define PMR_SB_LINK       2
`define PMR_PB_PAUSE      10
`define PMR_PB_ABIL_HI    8
`define PMR_PB_ABIL_LO    5
`define PMR_PREAMBLE_BITS 6'd32
`define PMR_OP_READ       2'b10
`define PMR_OP_WRITE      2'b01
`endif

// >>> hdl/pmr_pkg.sv
// Types shared by the PHY management register bank
package pmr_pkg;
   // Live state reported by one PHY and its switch port
   typedef struct packed {
      logic       link_up;
      logic       an_done;
      logic       far_fault;
      logic [4:0] partner;
   } pmr_phy_stat_t;
   // Settings handed to one PHY and its switch port
   typedef struct packed {
      logic       far_loopback;
      logic       force_100;
      logic       autoneg_enable;
      logic       power_down;
      logic       autoneg_restart;
      logic       full_duplex;
      logic       crossover_algorithm_select;
      logic       force_straight_wiring;
      logic       crossover_disable;
      logic       far_fault_disable;
      logic       tx_disable;
      logic       led_disable;
      logic [4:0] advertise;
   } pmr_phy_ctrl_t;
   typedef enum logic [2:0] {
      PMR_IDLE, PMR_START, PMR_OPCODE, PMR_PHY_SELECT_ADDRESS, PMR_PHY_REGISTER_INDEX, PMR_TURN, PMR_DATA
   } pmr_frame_t;
   typedef struct packed {
      logic                mdc_d;
      pmr_frame_t          frame;
      logic [5:0]          cnt;
      logic [1:0]          opcode;
      logic [4:0]          phy_addr;
      logic [4:0]          reg_idx;
      logic [15:0]         shift;
      logic                mdio_out;
      logic                mdio_oe;
      logic [1:0]          wr_pulse;
      pmr_phy_ctrl_t [1:0] ctrl_out;
      logic [15:0]         host_rdata;
      logic                host_rvalid;
   } pmr_top_st_t;
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] adv;
      logic [15:0] cable;
      logic [15:0] special;
   } pmr_regs_st_t;
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
   } pmr_sync_st_t;
endpackage : pmr_pkg

// >>> hdl/pmr_sync2.sv
// Two-flop synchroniser for the management clock and data pins
`timescale 1ns/1ps
`default_nettype none
module pmr_sync2
   import pmr_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [1:0] async_i,
   output logic [1:0]      sync_o
);
   pmr_sync_st_t st_r;
   pmr_sync_st_t st_nxt;

   // First stage feeds only the second
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = async_i;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_o = st_r.s2;
endmodule : pmr_sync2
`default_nettype wire

// >>> hdl/pmr_phy_regs.sv
// Register set of one integrated PHY
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.svh"
module pmr_phy_regs
   import pmr_pkg::*;
#(
   parameter logic [15:0] ID_HI = 16'h0abc, // Arbitrary identity value
   parameter logic [15:0] ID_LO = 16'h0def  // Arbitrary identity value
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          wr_i,
   input  wire logic [4:0]    wr_idx_i,
   input  wire logic [15:0]   wdata_i,
   input  wire logic [4:0]    rd_idx_a_i,
   input  wire logic [4:0]    rd_idx_b_i,
   input  wire pmr_phy_stat_t stat_i,
   output logic [15:0]        rdata_a_o,
   output logic [15:0]        rdata_b_o,
   output pmr_phy_ctrl_t      ctrl_o
);
   pmr_regs_st_t st_r;
   pmr_regs_st_t st_nxt;
   logic [15:0]  stat_w;
   logic [15:0]  partner_w;

   function automatic logic [15:0] pick(input logic [4:0] idx, input pmr_regs_st_t s,
                                        input logic [15:0] sw, input logic [15:0] pw);
      unique case (idx)
         `PMR_REG_CTRL:    pick = s.ctrl;
         `PMR_REG_STAT:    pick = sw;
         `PMR_REG_ID_HI:   pick = ID_HI;
         `PMR_REG_ID_LO:   pick = ID_LO;
         `PMR_REG_ADV:     pick = s.adv;
         `PMR_REG_PARTNER: pick = pw;
         `PMR_REG_CABLE:   pick = s.cable;
         `PMR_REG_SPECIAL: pick = s.special;
         default:          pick = 16'h0000; // Unsupported index
      endcase
   endfunction : pick

   // Status and partner words built live from port state
   always_comb begin
      stat_w                    = `PMR_STAT_FIXED;
      stat_w[`PMR_SB_AN_DONE]   = stat_i.an_done;
      stat_w[`PMR_SB_FAR_FAULT] = stat_i.far_fault;
      stat_w[`PMR_SB_AN_CAP]    = st_r.ctrl[`PMR_CB_AN_EN];
      stat_w[`PMR_SB_LINK]      = stat_i.link_up;
      partner_w                 = 16'h0000;
      partner_w[`PMR_PB_PAUSE]  = stat_i.partner[4];
      partner_w[`PMR_PB_ABIL_HI:`PMR_PB_ABIL_LO] = stat_i.partner[3:0];
      rdata_a_o = pick(rd_idx_a_i, st_r, stat_w, partner_w);
      rdata_b_o = pick(rd_idx_b_i, st_r, stat_w, partner_w);
   end

   // Writes keep read-only bits at their fixed values
   always_comb begin
      st_nxt = st_r;
      if (wr_i) begin
         unique case (wr_idx_i)
            `PMR_REG_CTRL:    st_nxt.ctrl    = wdata_i & `PMR_CTRL_RW_MASK;
            `PMR_REG_ADV:     st_nxt.adv     = (wdata_i & `PMR_ADV_RW_MASK)
                                             | (`PMR_ADV_RST & ~`PMR_ADV_RW_MASK);
            `PMR_REG_CABLE:   st_nxt.cable   = wdata_i;
            `PMR_REG_SPECIAL: st_nxt.special = wdata_i;
            default:          st_nxt.ctrl    = st_r.ctrl; // Other indexes ignore writes
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r.ctrl    <= `PMR_CTRL_RST;
         st_r.adv     <= `PMR_ADV_RST;
         st_r.cable   <= 16'h0000;
         st_r.special <= 16'h0000;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Control fields steering the PHY
   always_comb begin
      ctrl_o.far_loopback               = st_r.ctrl[`PMR_CB_LOOPBACK];
      ctrl_o.force_100                  = st_r.ctrl[`PMR_CB_FORCE100];
      ctrl_o.autoneg_enable             = st_r.ctrl[`PMR_CB_AN_EN];
      ctrl_o.power_down                 = st_r.ctrl[`PMR_CB_PWR_DOWN];
      ctrl_o.autoneg_restart            = st_r.ctrl[`PMR_CB_AN_RESTART];
      ctrl_o.full_duplex                = st_r.ctrl[`PMR_CB_FULL_DPX];
      ctrl_o.crossover_algorithm_select = st_r.ctrl[`PMR_CB_XOVER_ALG];
      ctrl_o.force_straight_wiring      = st_r.ctrl[`PMR_CB_STRAIGHT];
      ctrl_o.crossover_disable          = st_r.ctrl[`PMR_CB_XOVER_DIS];
      ctrl_o.far_fault_disable          = st_r.ctrl[`PMR_CB_FEF_DIS];
      ctrl_o.tx_disable                 = st_r.ctrl[`PMR_CB_TX_DIS];
      ctrl_o.led_disable                = st_r.ctrl[`PMR_CB_LED_DIS];
      ctrl_o.advertise = {st_r.adv[`PMR_PB_PAUSE], st_r.adv[`PMR_PB_ABIL_HI:`PMR_PB_ABIL_LO]};
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ctrl_rst_a: assert property ($past(rst_i) |-> st_r.ctrl == `PMR_CTRL_RST)
      else $error("control word not at reset value");
   stat_fixed_a: assert property (rdata_a_o[15:6] == 10'h1e0 || rd_idx_a_i != `PMR_REG_STAT)
      else $error("fixed status bits wrong");
   unsup_zero_a: assert property (rd_idx_a_i inside {[5'h06:5'h1c], 5'h1e} |-> rdata_a_o == 16'h0000)
      else $error("unsupported index reads nonzero");
   ctrl_write_a: assert property (wr_i && wr_idx_i == `PMR_REG_CTRL |=> ctrl_o.far_loopback == $past(wdata_i[14]))
      else $error("loopback bit not written");
   ro_bits_a: assert property ((st_r.ctrl & ~`PMR_CTRL_RW_MASK) == 16'h0000)
      else $error("unsupported control bits set");
   an_cap_a: assert property (stat_w[`PMR_SB_AN_CAP] == ctrl_o.autoneg_enable && stat_w[0] == 1'b0)
      else $error("capability bit does not follow enable");
endmodule : pmr_phy_regs
`default_nettype wire

// >>> hdl/pmr_top.sv
// Top of the PHY management register bank: serial frame engine and address decode
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.svh"
// Functional notes
// - Both PHY register sets are read and written over the serial management pins.
// - A subset is also reachable through a host port with its own mapping.
// - After reset the first PHY answers address 1, the second address 2.
// - A five-bit global control field reprograms the answered PHY addresses.
// - Only register indexes 0 to 5, 0x1d and 0x1f are implemented.
// - Indexes 6 to 0x1c and 0x1e are unsupported and carry no function.
// - First PHY control bit 14 wraps port 2 traffic at port 1.
// - Second PHY control bit 14 wraps port 1 traffic at port 2.
// - Control bit 5 picks the crossover algorithm, one by default.
// - Control bit 4 forces straight wiring, transmitting on the receive pair.
// - Control bit 3 disables automatic crossover detection, clear at reset.
// - Control bit 2 disables far-end fault detection, clear at reset.
// - Status bits 14 to 11 always read one for the four fixed modes.
// - Status bit 15 and reserved bits 10 to 7 read zero.
// - Status bit 0 and preamble suppression bit 6 read zero.
// - Status bit 5 shows auto-negotiation done, zero after reset.
// - Status bit 4 shows a detected far-end fault, zero after reset.
// - Status bit 3 shows auto-negotiation capability, one after reset.
// - Loopback alternatively from switch side; both ports then run at 100 Mbps.
module pmr_top
   import pmr_pkg::*;
(
   input  wire logic                CLK_I,
   input  wire logic                RESET_I,
   input  wire logic                MDC_I,
   input  wire logic                MDIO_I,
   output logic                     MDIO_O,
   output logic                     MDIO_OE_O,
   input  wire logic [7:0]          GLOBAL_CTRL15_I,
   input  wire pmr_phy_stat_t [1:0] PHY_STAT_I,
   output pmr_phy_ctrl_t [1:0]      PHY_CTRL_O,
   input  wire logic                HOST_WR_I,
   input  wire logic                HOST_RD_I,
   input  wire logic [3:0]          HOST_ADDR_I,
   input  wire logic [15:0]         HOST_WDATA_I,
   output logic [15:0]              HOST_RDATA_O,
   output logic                     HOST_RVALID_O
);
   pmr_top_st_t         st_r;
   pmr_top_st_t         st_nxt;
   logic [1:0]          pins_s;
   logic                mdc_s;
   logic                mdio_s;
   logic                bit_tick;
   logic [4:0]          addr_fld;
   logic [1:0][4:0]     phy_addr;
   logic [1:0]          phy_hit;
   logic                any_hit;
   logic                sel_phy;
   logic [1:0]          host_wr;
   logic [1:0]          wr_en;
   logic [1:0][4:0]     wr_idx;
   logic [1:0][15:0]    wr_data;
   logic [1:0][15:0]    rdata_a;
   logic [1:0][15:0]    rdata_b;
   logic [4:0]          host_idx;
   logic                loop_any;
   pmr_phy_ctrl_t [1:0] ctrl_w;

   // Both pins come from the far station, so they are synchronised first
   pmr_sync2 u_sync (
      .clk_i   (CLK_I),
      .rst_i   (RESET_I),
      .async_i ({MDC_I, MDIO_I}),
      .sync_o  (pins_s)
   );

   // Rising management clock marks one serial bit
   always_comb begin
      mdc_s    = pins_s[1];
      mdio_s   = pins_s[0];
      bit_tick = mdc_s && !st_r.mdc_d;
   end

   // Answered PHY addresses: defaults while the global field is zero
   always_comb begin
      addr_fld = GLOBAL_CTRL15_I[`PMR_ADDR_FLD_HI:`PMR_ADDR_FLD_LO];
      if (addr_fld == 5'h00) begin
         phy_addr[0] = `PMR_PHY1_ADDR_RST;
         phy_addr[1] = `PMR_PHY2_ADDR_RST;
      end else begin
         phy_addr[0] = addr_fld;
         phy_addr[1] = addr_fld + 5'h01;
      end
      phy_hit[0] = (st_r.phy_addr == phy_addr[0]);
      phy_hit[1] = (st_r.phy_addr == phy_addr[1]);
      any_hit    = |phy_hit;
      sel_phy    = phy_hit[1];
   end

   // Host port maps bit 3 to the PHY and bits 2:0 to the register index
   always_comb begin
      host_idx = {2'b00, HOST_ADDR_I[2:0]};
      loop_any = ctrl_w[0].far_loopback || ctrl_w[1].far_loopback;
   end

   // One register set per PHY; serial writes win over host writes
   generate
      for (genvar n = 0; n < 2; n++) begin : g_phy
         always_comb begin
            host_wr[n] = HOST_WR_I && (HOST_ADDR_I[3] == 1'(n));
            wr_en[n]   = st_r.wr_pulse[n] || host_wr[n];
            wr_idx[n]  = st_r.wr_pulse[n] ? st_r.reg_idx : host_idx;
            wr_data[n] = st_r.wr_pulse[n] ? st_r.shift : HOST_WDATA_I;
         end
         pmr_phy_regs u_regs (
            .clk_i      (CLK_I),
            .rst_i      (RESET_I),
            .wr_i       (wr_en[n]),
            .wr_idx_i   (wr_idx[n]),
            .wdata_i    (wr_data[n]),
            .rd_idx_a_i (st_r.reg_idx),
            .rd_idx_b_i (host_idx),
            .stat_i     (PHY_STAT_I[n]),
            .rdata_a_o  (rdata_a[n]),
            .rdata_b_o  (rdata_b[n]),
            .ctrl_o     (ctrl_w[n])
         );
      end
   endgenerate

   // Frame engine, host answers and registered PHY settings
   always_comb begin
      st_nxt             = st_r;
      st_nxt.mdc_d       = mdc_s;
      st_nxt.wr_pulse    = 2'b00;
      st_nxt.host_rvalid = 1'b0;
      // Host read answers one cycle after the strobe
      if (HOST_RD_I) begin
         st_nxt.host_rdata  = rdata_b[HOST_ADDR_I[3]];
         st_nxt.host_rvalid = 1'b1;
      end
      // Loopback needs both ports at 100 Mbps, so speed is forced while it is on
      for (int n = 0; n < 2; n++) begin
         st_nxt.ctrl_out[n]           = ctrl_w[n];
         st_nxt.ctrl_out[n].force_100 = ctrl_w[n].force_100 || loop_any;
      end
      if (bit_tick) begin
         unique case (st_r.frame)
            // Preamble suppression is absent: 32 ones must precede each frame
            PMR_IDLE: begin
               if (mdio_s) begin
                  if (st_r.cnt != `PMR_PREAMBLE_BITS) begin
                     st_nxt.cnt = st_r.cnt + 6'd1;
                  end
               end else begin
                  if (st_r.cnt == `PMR_PREAMBLE_BITS) begin
                     st_nxt.frame = PMR_START;
                  end
                  st_nxt.cnt = 6'd0;
               end
            end
            // Second start bit must be a one
            PMR_START: begin
               st_nxt.frame = mdio_s ? PMR_OPCODE : PMR_IDLE;
               st_nxt.cnt   = 6'd0;
            end
            // Two opcode bits; anything but read or write drops the frame
            PMR_OPCODE: begin
               st_nxt.opcode = {st_r.opcode[0], mdio_s};
               if (st_r.cnt == 6'd1) begin
                  st_nxt.cnt = 6'd0;
                  if (st_nxt.opcode == `PMR_OP_READ || st_nxt.opcode == `PMR_OP_WRITE) begin
                     st_nxt.frame = PMR_PHY_SELECT_ADDRESS;
                  end else begin
                     st_nxt.frame = PMR_IDLE;
                  end
               end else begin
                  st_nxt.cnt = st_r.cnt + 6'd1;
               end
            end
            // Five PHY address bits, most significant first
            PMR_PHY_SELECT_ADDRESS: begin
               st_nxt.phy_addr = {st_r.phy_addr[3:0], mdio_s};
               if (st_r.cnt == 6'd4) begin
                  st_nxt.frame = PMR_PHY_REGISTER_INDEX;
                  st_nxt.cnt   = 6'd0;
               end else begin
                  st_nxt.cnt = st_r.cnt + 6'd1;
               end
            end
            // Five register index bits
            PMR_PHY_REGISTER_INDEX: begin
               st_nxt.reg_idx = {st_r.reg_idx[3:0], mdio_s};
               if (st_r.cnt == 6'd4) begin
                  st_nxt.frame = PMR_TURN;
                  st_nxt.cnt   = 6'd0;
               end else begin
                  st_nxt.cnt = st_r.cnt + 6'd1;
               end
            end
            // Turnaround: on a read the addressed PHY drives zero in the second bit
            PMR_TURN: begin
               if (st_r.cnt == 6'd0) begin
                  st_nxt.cnt = 6'd1;
                  if (st_r.opcode == `PMR_OP_READ && any_hit) begin
                     st_nxt.mdio_oe  = 1'b1;
                     st_nxt.mdio_out = 1'b0;
                  end
               end else begin
                  st_nxt.frame = PMR_DATA;
                  st_nxt.cnt   = 6'd0;
                  if (st_r.mdio_oe) begin
                     st_nxt.mdio_out = rdata_a[sel_phy][15];
                     st_nxt.shift    = {rdata_a[sel_phy][14:0], 1'b0};
                  end
               end
            end
            // Sixteen data bits, shifted out on a read or in on a write
            PMR_DATA: begin
               if (st_r.opcode == `PMR_OP_READ) begin
                  if (st_r.cnt == 6'd15) begin
                     st_nxt.mdio_oe  = 1'b0;
                     st_nxt.mdio_out = 1'b0;
                  end else begin
                     st_nxt.mdio_out = st_r.shift[15];
                     st_nxt.shift    = {st_r.shift[14:0], 1'b0};
                  end
               end else begin
                  st_nxt.shift = {st_r.shift[14:0], mdio_s};
                  if (st_r.cnt == 6'd15) begin
                     st_nxt.wr_pulse = phy_hit;
                  end
               end
               if (st_r.cnt == 6'd15) begin
                  st_nxt.frame = PMR_IDLE;
                  st_nxt.cnt   = 6'd0;
               end else begin
                  st_nxt.cnt = st_r.cnt + 6'd1;
               end
            end
         endcase
      end
   end

   // Settings outputs read zero for as long as reset is held
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // All outputs straight from the state register
   assign MDIO_O        = st_r.mdio_out;
   assign MDIO_OE_O     = st_r.mdio_oe;
   assign PHY_CTRL_O    = st_r.ctrl_out;
   assign HOST_RDATA_O  = st_r.host_rdata;
   assign HOST_RVALID_O = st_r.host_rvalid;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   tick_pulse_a: assert property (bit_tick |=> !bit_tick)
      else $error("bit tick longer than one cycle");
   turn_drive_a: assert property ($rose(MDIO_OE_O) |-> !MDIO_O && st_r.frame == PMR_TURN)
      else $error("read drive did not open with a zero in turnaround");
   drive_end_a: assert property ($fell(MDIO_OE_O) |-> st_r.frame == PMR_IDLE)
      else $error("drive released outside frame end");
   addr_default_a: assert property (addr_fld == 5'h00 |-> phy_addr == {5'h02, 5'h01})
      else $error("default PHY addresses wrong");
   addr_prog_a: assert property (addr_fld != 5'h00 |-> phy_addr[0] == addr_fld)
      else $error("programmed PHY address not taken");
   host_read_a: assert property (HOST_RD_I |=> HOST_RVALID_O
                                 && HOST_RDATA_O == $past(rdata_b[HOST_ADDR_I[3]]))
      else $error("host read answer wrong");
   loop_speed_a: assert property (loop_any |=> PHY_CTRL_O[0].force_100
                                  && PHY_CTRL_O[1].force_100)
      else $error("loopback without forced 100 Mbps");
   write_hit_a: assert property (|st_r.wr_pulse |-> st_r.opcode == `PMR_OP_WRITE
                                 && st_r.frame == PMR_IDLE)
      else $error("register write outside a write frame");
endmodule : pmr_top
`default_nettype wire

// >>> tb/pmr_mdio_master.sv
// Station management master model for the serial management pins
`timescale 1ns/1ps
`default_nettype none
module pmr_mdio_master (
   input  wire logic clk_i,
   input  wire logic mdio_i,
   output logic      mdc_o = 1'b0,
   output logic      mdio_o = 1'b1,
   output logic      mdio_oe_o = 1'b0
);
   // Six core cycles per phase, twice what the receiver needs
   task automatic bit_cyc(input logic oe, input logic d, output logic q);
      @(posedge clk_i) mdio_oe_o <= oe;
      mdio_o <= d;
      repeat (6) @(posedge clk_i);
      mdc_o <= 1'b1;
      q = mdio_i;
      repeat (6) @(posedge clk_i);
      mdc_o <= 1'b0;
   endtask : bit_cyc
   // Fresh preamble each frame; line released over turnaround and data on reads
   task automatic frame(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] f;
      logic        q;
      f = {32'hffffffff, 2'b01, wr ? 2'b01 : 2'b10, pa, ra, 2'b10, wd};
      for (int i = 63; i >= 0; i--) begin
         bit_cyc(wr || i > 17, f[i], q);
         if (i < 16)
            rd[i] = q;
      end
      @(posedge clk_i) mdio_oe_o <= 1'b0;
   endtask : frame
endmodule : pmr_mdio_master
`default_nettype wire

// >>> tb/pmr_top_tb.sv
// Self-checking bench for the PHY management register bank
`timescale 1ns/1ps
`default_nettype none
module pmr_top_tb
   import pmr_pkg::*;
();
   typedef struct packed {
      logic        wr;
      logic [4:0]  pa;
      logic [4:0]  ra;
      logic [15:0] wd;
      logic [15:0] exp;
   } pmr_row_t;
   // Optional write, then serial read back
   localparam pmr_row_t ROWS [11] = '{
      '{1'b0, 5'h01, 5'h00, 16'h0000, 16'h1020},
      '{1'b0, 5'h01, 5'h01, 16'h0000, 16'h782c},
      '{1'b0, 5'h02, 5'h01, 16'h0000, 16'h7818},
      '{1'b1, 5'h01, 5'h00, 16'hffff, 16'h7b3f},
      '{1'b1, 5'h02, 5'h00, 16'h0000, 16'h0000},
      '{1'b0, 5'h02, 5'h01, 16'h0000, 16'h7810},
      '{1'b1, 5'h01, 5'h1d, 16'h1234, 16'h1234},
      '{1'b1, 5'h02, 5'h06, 16'hffff, 16'h0000},
      '{1'b1, 5'h01, 5'h1e, 16'hffff, 16'h0000},
      '{1'b1, 5'h01, 5'h01, 16'h0000, 16'h782c}, // Read-only status
      '{1'b0, 5'h03, 5'h00, 16'h0000, 16'hffff}  // Nobody answers
   };
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic [7:0]          gctl = 8'h00;
   pmr_phy_stat_t [1:0] stat = 16'h20df; // PHY2 fault only; PHY1 link, done, all abilities
   pmr_phy_ctrl_t [1:0] ctrl;
   logic                hrd = 1'b0;
   logic                hwr = 1'b0;
   logic [15:0]         hwd = 16'hffff;
   logic [3:0]          haddr = 4'h0;
   logic [15:0]         hrdata, rd;
   logic                hrv, mdc, m_do, m_oe, d_do, d_oe, mdio;
   int                  miscompares = 0, num_checks = 0, cyc = 0;
   always #2 clk = ~clk;
   // Pull-up holds the line high when released
   assign mdio = d_oe ? d_do : (m_oe ? m_do : 1'b1);
   pmr_mdio_master mst (.clk_i(clk), .mdio_i(mdio), .mdc_o(mdc), .mdio_o(m_do),
                        .mdio_oe_o(m_oe));
   pmr_top dut (.CLK_I(clk), .RESET_I(rst), .MDC_I(mdc), .MDIO_I(mdio), .MDIO_O(d_do),
                .MDIO_OE_O(d_oe), .GLOBAL_CTRL15_I(gctl), .PHY_STAT_I(stat),
                .PHY_CTRL_O(ctrl), .HOST_WR_I(hwr), .HOST_RD_I(hrd), .HOST_ADDR_I(haddr),
                .HOST_WDATA_I(hwd), .HOST_RDATA_O(hrdata), .HOST_RVALID_O(hrv));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   // Hang guard, about two and a half times the expected run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         miscompares++;
         complete_run();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      foreach (ROWS[i]) begin
         if (ROWS[i].wr)
            mst.frame(1'b1, ROWS[i].pa, ROWS[i].ra, ROWS[i].wd, rd);
         mst.frame(1'b0, ROWS[i].pa, ROWS[i].ra, 16'h0000, rd);
         check(rd, ROWS[i].exp);
      end
      check({12'h000, ctrl[0].far_loopback, ctrl[1].far_loopback, ctrl[1].force_100,
             ctrl[1].crossover_algorithm_select}, 16'h000a);
      $display("table done");
      // Host port read of PHY2 status, answer one edge later
      @(posedge clk) hrd <= 1'b1;
      haddr <= 4'h9;
      @(posedge clk) hrd <= 1'b0;
      #1;
      check({15'h0000, hrv}, 16'h0001);
      check(hrdata, 16'h7810);
      // Host write clears PHY1 advertisement; selector stays, read back by host
      @(posedge clk) hwr <= 1'b1;
      haddr <= 4'h4;
      hwd <= 16'h0000;
      @(posedge clk) hwr <= 1'b0;
      hrd <= 1'b1;
      @(posedge clk) hrd <= 1'b0;
      #1;
      check(hrdata, 16'h0001);
      check({11'h000, ctrl[0].advertise}, 16'h0000);
      $display("host read done");
      // Programmed address moves PHY1 away from its default
      @(posedge clk) gctl <= 8'h40;
      mst.frame(1'b0, 5'h08, 5'h00, 16'h0000, rd);
      check(rd, 16'h7b3f);
      mst.frame(1'b0, 5'h01, 5'h00, 16'h0000, rd);
      check(rd, 16'hffff);
      $display("address program done");
      // Second reset in mid-run restores defaults
      @(posedge clk) rst <= 1'b1;
      gctl <= 8'h00;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      mst.frame(1'b0, 5'h01, 5'h00, 16'h0000, rd);
      check(rd, 16'h1020);
      $display("reset done");
      complete_run();
   end
endmodule : pmr_top_tb
`default_nettype wire
